/* File: efcf_pkg.sv */
// Shared constants, enumerations and carrier structs for the capture front end
package efcf_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCH     = 16;          // External data channels
  localparam int GRP_W   = 8;           // Channels per threshold group
  localparam int THR_W   = 8;           // Threshold code, 50 mV steps
  localparam logic [NCH-1:0] ALL_CH  = 16'hFFFF;
  localparam logic [NCH-1:0] NONE_CH = 16'h0000;

  // ----------------------------------------------------------------
  // Maximum qualified clock rates per speed setting, in MHz
  // ----------------------------------------------------------------
  localparam int SLOW_MHZ  = 16;
  localparam int FAST_MHZ  = 20;
  localparam int VFAST_MHZ = 25;

  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_EXTEND = 2'h0,
    MODE_STATE  = 2'h1,
    MODE_TIMING = 2'h2,
    MODE_BAD    = 2'h3
  } efcf_mode_t;

  typedef enum logic [1:0] {
    SPD_SLOW  = 2'h0,
    SPD_FAST  = 2'h1,
    SPD_VFAST = 2'h2,
    SPD_BAD   = 2'h3
  } efcf_speed_t;

  typedef enum logic [1:0] {
    CNTQ_OFF   = 2'h0,
    CNTQ_STATE = 2'h1,
    CNTQ_TIME  = 2'h2,
    CNTQ_BAD   = 2'h3
  } efcf_cntq_t;

  typedef enum logic [2:0] {
    CK_OFF  = 3'h0,
    CK_RISE = 3'h1,
    CK_FALL = 3'h2,
    CK_BOTH = 3'h3,
    CK_HIGH = 3'h4,
    CK_LOW  = 3'h5
  } efcf_ckcfg_t;

  typedef enum logic [3:0] {
    FSM_IDLE = 4'h1,
    FSM_ARM  = 4'h2,
    FSM_RUN  = 4'h4,
    FSM_DONE = 4'h8
  } efcf_fsm_t;

  // ----------------------------------------------------------------
  // Trace configuration, latched at trace start
  // ----------------------------------------------------------------
  typedef struct packed {
    efcf_mode_t       mode;
    efcf_speed_t      speed;
    efcf_cntq_t       cntq;
    efcf_ckcfg_t      ck_first;
    efcf_ckcfg_t      ck_second;
    logic [THR_W-1:0] thr_lo;
    logic [THR_W-1:0] thr_hi;
    logic             arm_by_other;
  } efcf_cfg_t;

endpackage

/* File: efcf_sync.sv */
// Three-stage input synchroniser with second/third stage agreement filter
`timescale 1ns/100ps
`default_nettype none

module efcf_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  // Asynchronous inputs and filtered result
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  // Stage values and filtered result kept as one state word
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } efcf_sync_st_t;

  efcf_sync_st_t st_r;
  efcf_sync_st_t st_nxt;

  // ----------------------------------------------------------------
  // Chain; stage one feeds only stage two
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // Change counts only once two stages agree; a split keeps the old value
    st_nxt.q  = (st_r.s2 & st_r.s3) | (st_r.q & (st_r.s2 | st_r.s3));
  end

  // State register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.q;

endmodule

`default_nettype wire

/* File: efcf_front.sv */
// Capture front end: modes, labels, qualified clocks, speed checks, arming
//
// Function
// - Sixteen channels; default label covers all.
// - New labels start empty; set bits include.
// - Exactly three modes: extend, state, timing.
// - Extend mode samples with emulation bus state.
// - State mode has own sixteen-bit trace store.
// - Independent modes let analyzers arm each other.
// - Each clock input: rise, fall or both.
// - High/low qualifier gates the other input's edges.
// - Off input neither clocks nor qualifies.
// - Any selected edge of either input samples.
// - Slow: 16 MHz, count qualifier unrestricted.
// - Fast: 20 MHz, count states only.
// - Very fast: 25 MHz, count qualifier off.
// - Two threshold groups: channels 0-7, 8-15.
// - Below threshold reads 0, above reads 1.
`timescale 1ns/100ps
`default_nettype none

module efcf_front #(
  parameter int NLBL  = 4,
  parameter int DEPTH = 8,
  parameter int EMU_W = 32
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rstn,
  // Probe pins: comparator outputs and clock inputs
  input  wire logic [efcf_pkg::NCH-1:0]   chan_above,
  input  wire logic                       first_ext_clock_in,
  input  wire logic                       second_ext_clock_in,
  // Emulation bus state, same clock domain
  input  wire logic                       emu_valid,
  input  wire logic [EMU_W-1:0]           emu_bus,
  // Configuration and control
  input  wire efcf_pkg::efcf_cfg_t        cfg_in,
  input  wire logic                       trace_start,
  input  wire logic                       trace_stop,
  input  wire logic                       lbl_we,
  input  wire logic [$clog2(NLBL)-1:0]    lbl_idx,
  input  wire logic [efcf_pkg::NCH-1:0]   lbl_mask,
  input  wire logic [$clog2(NLBL)-1:0]    trig_lbl,
  input  wire logic [efcf_pkg::NCH-1:0]   trig_pat,
  input  wire logic [$clog2(DEPTH)-1:0]   rd_idx,
  // Cross arming
  input  wire logic                       other_trig_in,
  output var  logic                       arm_other_out,
  // Threshold codes to the comparators
  output var  logic [efcf_pkg::THR_W-1:0] thr_lo_out,
  output var  logic [efcf_pkg::THR_W-1:0] thr_hi_out,
  // Status and data
  output var  efcf_pkg::efcf_fsm_t        fsm_out,
  output var  logic                       cfg_err_out,
  output var  logic                       trig_out,
  output var  logic [NLBL*efcf_pkg::NCH-1:0] lbl_masks_out,
  output var  logic [efcf_pkg::NCH-1:0]   rd_data,
  output var  logic                       comb_valid,
  output var  logic [efcf_pkg::NCH+EMU_W-1:0] comb_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] LAST = (AW+1)'(DEPTH - 1);

  typedef struct packed {
    efcf_pkg::efcf_fsm_t                   fsm;
    efcf_pkg::efcf_cfg_t                   cfg;
    logic [NLBL-1:0][efcf_pkg::NCH-1:0]    mask;
    logic                                  jp;
    logic                                  kp;
    logic                                  trig;
    logic                                  trigd;
    logic                                  cfg_err;
    logic                                  arm;
    logic [AW:0]                           cnt;
    logic [DEPTH-1:0][efcf_pkg::NCH-1:0]   mem;
    logic [efcf_pkg::NCH-1:0]              rd;
    logic                                  cv;
    logic [efcf_pkg::NCH+EMU_W-1:0]        cd;
  } efcf_st_t;

  efcf_st_t                 st_r;
  efcf_st_t                 st_nxt;
  logic [efcf_pkg::NCH+1:0] pin_s;
  logic [efcf_pkg::NCH-1:0] chan_s;
  logic                     j_s;
  logic                     k_s;
  logic                     tick;
  logic                     store;
  logic                     indep;
  logic                     bad_cfg;
  logic                     hit;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  efcf_sync #(.W(efcf_pkg::NCH + 2)) u_sync (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .async_in ({second_ext_clock_in, first_ext_clock_in, chan_above}),
    .sync_out (pin_s)
  );

  // Comparator already resolves level: above threshold is 1
  assign chan_s = pin_s[efcf_pkg::NCH-1:0];
  assign j_s    = pin_s[efcf_pkg::NCH];
  assign k_s    = pin_s[efcf_pkg::NCH+1];

  // ----------------------------------------------------------------
  // Clock qualification helpers
  // ----------------------------------------------------------------
  function automatic logic edge_ok(efcf_pkg::efcf_ckcfg_t c, logic now, logic prv);
    unique case (c)
      efcf_pkg::CK_RISE: edge_ok = now & ~prv;
      efcf_pkg::CK_FALL: edge_ok = ~now & prv;
      efcf_pkg::CK_BOTH: edge_ok = now ^ prv;
      default:           edge_ok = 1'b0;
    endcase
  endfunction

  function automatic logic qual_ok(efcf_pkg::efcf_ckcfg_t c, logic lvl);
    unique case (c)
      efcf_pkg::CK_HIGH: qual_ok = lvl;
      efcf_pkg::CK_LOW:  qual_ok = ~lvl;
      default:           qual_ok = 1'b1;
    endcase
  endfunction

  // Qualified sample tick from the latched clock settings
  assign tick = (edge_ok(st_r.cfg.ck_first, j_s, st_r.jp)
                 & qual_ok(st_r.cfg.ck_second, k_s))
              | (edge_ok(st_r.cfg.ck_second, k_s, st_r.kp)
                 & qual_ok(st_r.cfg.ck_first, j_s));

  assign indep = (st_r.cfg.mode == efcf_pkg::MODE_STATE)
               | (st_r.cfg.mode == efcf_pkg::MODE_TIMING);

  // Speed against count qualifier, and illegal codes
  // Slow speed adds no term: every count qualifier use stays legal
  assign bad_cfg = (cfg_in.mode == efcf_pkg::MODE_BAD)
                 | (cfg_in.speed == efcf_pkg::SPD_BAD)
                 | (cfg_in.cntq == efcf_pkg::CNTQ_BAD)
                 | (cfg_in.speed == efcf_pkg::SPD_FAST
                    && cfg_in.cntq == efcf_pkg::CNTQ_TIME)
                 | (cfg_in.speed == efcf_pkg::SPD_VFAST
                    && cfg_in.cntq != efcf_pkg::CNTQ_OFF);

  // Store strobe per mode; timing mode samples every ref clock
  always_comb begin
    unique case (st_r.cfg.mode)
      efcf_pkg::MODE_EXTEND: store = emu_valid;
      efcf_pkg::MODE_STATE:  store = tick;
      efcf_pkg::MODE_TIMING: store = 1'b1;
      default:               store = 1'b0;
    endcase
  end

  assign hit = ((chan_s ^ trig_pat) & st_r.mask[trig_lbl]) == efcf_pkg::NONE_CH;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.trig = 1'b0;
    st_nxt.arm  = 1'b0;
    st_nxt.cv   = 1'b0;
    st_nxt.jp   = j_s;
    st_nxt.kp   = k_s;
    st_nxt.rd   = st_r.mem[rd_idx];
    // Label zero is the fixed all-channel label
    if (lbl_we && lbl_idx != '0) begin
      st_nxt.mask[lbl_idx] = lbl_mask;
    end
    unique case (st_r.fsm)
      efcf_pkg::FSM_IDLE, efcf_pkg::FSM_DONE: begin
        if (trace_start) begin
          if (bad_cfg) begin
            st_nxt.cfg_err = 1'b1;
          end else begin
            // Settings only land here, never mid-trace
            st_nxt.cfg_err = 1'b0;
            st_nxt.cfg     = cfg_in;
            st_nxt.cnt     = '0;
            st_nxt.trigd   = 1'b0;
            st_nxt.fsm     = (cfg_in.arm_by_other && cfg_in.mode != efcf_pkg::MODE_EXTEND)
                           ? efcf_pkg::FSM_ARM : efcf_pkg::FSM_RUN;
          end
        end
      end
      efcf_pkg::FSM_ARM: begin
        if (trace_stop) begin
          st_nxt.fsm = efcf_pkg::FSM_IDLE;
        end else if (other_trig_in) begin
          st_nxt.fsm = efcf_pkg::FSM_RUN;
        end
      end
      efcf_pkg::FSM_RUN: begin
        if (trace_stop) begin
          st_nxt.fsm = efcf_pkg::FSM_DONE;
        end else if (store) begin
          st_nxt.mem[st_r.cnt[AW-1:0]] = chan_s;
          st_nxt.cnt = st_r.cnt + 1'b1;
          if (hit && !st_r.trigd) begin
            st_nxt.trig  = 1'b1;
            st_nxt.trigd = 1'b1;
            st_nxt.arm   = indep;
          end
          if (st_r.cnt == LAST) begin
            st_nxt.fsm = efcf_pkg::FSM_DONE;
          end
        end
        // One combined state: probe bits beside the emulation bus
        if (st_r.cfg.mode == efcf_pkg::MODE_EXTEND && emu_valid) begin
          st_nxt.cv = 1'b1;
          st_nxt.cd = {chan_s, emu_bus};
        end
      end
      default: st_nxt.fsm = efcf_pkg::FSM_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r          <= '0;
      st_r.fsm      <= efcf_pkg::FSM_IDLE;
      st_r.mask[0]  <= efcf_pkg::ALL_CH;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign fsm_out       = st_r.fsm;
  assign cfg_err_out   = st_r.cfg_err;
  assign trig_out      = st_r.trig;
  assign arm_other_out = st_r.arm;
  assign thr_lo_out    = st_r.cfg.thr_lo;
  assign thr_hi_out    = st_r.cfg.thr_hi;
  assign lbl_masks_out = st_r.mask;
  assign rd_data       = st_r.rd;
  assign comb_valid    = st_r.cv;
  assign comb_data     = st_r.cd;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_lbl0;
    @(posedge ref_clk) disable iff (!rstn) st_r.mask[0] == efcf_pkg::ALL_CH;
  endproperty
  a_lbl0: assert property (p_lbl0) else $error("default label lost a channel");

  property p_lbl_wr;
    @(posedge ref_clk) disable iff (!rstn)
      lbl_we && lbl_idx != '0 |=> st_r.mask[$past(lbl_idx)] == $past(lbl_mask);
  endproperty
  a_lbl_wr: assert property (p_lbl_wr) else $error("label mask not written");

  property p_mode_ok;
    @(posedge ref_clk) disable iff (!rstn)
      st_r.fsm != efcf_pkg::FSM_IDLE |-> st_r.cfg.mode != efcf_pkg::MODE_BAD;
  endproperty
  a_mode_ok: assert property (p_mode_ok) else $error("illegal mode running");

  property p_extend;
    @(posedge ref_clk) disable iff (!rstn)
      st_r.fsm == efcf_pkg::FSM_RUN && st_r.cfg.mode == efcf_pkg::MODE_EXTEND
      && emu_valid && !trace_stop |=> comb_valid && comb_data == $past({chan_s, emu_bus});
  endproperty
  a_extend: assert property (p_extend) else $error("combined state wrong");

  property p_arm;
    @(posedge ref_clk) disable iff (!rstn)
      st_r.fsm == efcf_pkg::FSM_ARM && other_trig_in && !trace_stop
      |=> st_r.fsm == efcf_pkg::FSM_RUN;
  endproperty
  a_arm: assert property (p_arm) else $error("cross arm ignored");

  property p_qual;
    @(posedge ref_clk) disable iff (!rstn)
      st_r.cfg.ck_second == efcf_pkg::CK_HIGH && !k_s |-> !tick;
  endproperty
  a_qual: assert property (p_qual) else $error("edge passed closed qualifier");

  property p_off;
    @(posedge ref_clk) disable iff (!rstn)
      st_r.cfg.ck_first == efcf_pkg::CK_OFF && st_r.cfg.ck_second == efcf_pkg::CK_OFF |-> !tick;
  endproperty
  a_off: assert property (p_off) else $error("tick with both inputs off");

  property p_any_edge;
    @(posedge ref_clk) disable iff (!rstn)
      st_r.cfg.ck_first == efcf_pkg::CK_RISE && st_r.cfg.ck_second == efcf_pkg::CK_FALL
      && !k_s && st_r.kp |-> tick;
  endproperty
  a_any_edge: assert property (p_any_edge) else $error("selected edge missed");

  property p_conflict;
    @(posedge ref_clk) disable iff (!rstn)
      trace_start && (st_r.fsm == efcf_pkg::FSM_IDLE) && cfg_in.speed == efcf_pkg::SPD_VFAST
      && cfg_in.cntq != efcf_pkg::CNTQ_OFF |=> cfg_err_out && st_r.fsm == efcf_pkg::FSM_IDLE;
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflicting start accepted");

  property p_hold_thr;
    @(posedge ref_clk) disable iff (!rstn)
      st_r.fsm == efcf_pkg::FSM_RUN ##1 st_r.fsm == efcf_pkg::FSM_RUN
      |-> $stable(thr_lo_out) && $stable(thr_hi_out);
  endproperty
  a_hold_thr: assert property (p_hold_thr) else $error("threshold moved mid trace");

  c_ext_run:  cover property (@(posedge ref_clk) disable iff (!rstn) comb_valid);
  c_trig:     cover property (@(posedge ref_clk) disable iff (!rstn) trig_out && arm_other_out);
  c_full:     cover property (@(posedge ref_clk) disable iff (!rstn)
                              st_r.fsm == efcf_pkg::FSM_RUN ##1 st_r.fsm == efcf_pkg::FSM_DONE);
  c_err:      cover property (@(posedge ref_clk) disable iff (!rstn) $rose(cfg_err_out));

endmodule

`default_nettype wire

/* File: efcf_target.sv */
// Target-side model: two probe clocks and sixteen comparator outputs
`timescale 1ns/100ps
`default_nettype none

module efcf_target (
  // Threshold codes from the front end
  input  wire logic [7:0]  thr_lo,
  input  wire logic [7:0]  thr_hi,
  // Probe pins
  output var  logic [15:0] chan_above,
  output var  logic        first_ext_clock_in,
  output var  logic        second_ext_clock_in
);
  // ----------------------------------------------------------------
  // Target levels and comparators
  // ----------------------------------------------------------------
  logic [15:0] pat = 16'h0000;

  // A one sits at 2.5 V, a zero at 0 V, codes in 50 mV steps
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      chan_above[i] = $signed(pat[i] ? 8'h32 : 8'h00) >
                      $signed(i < 8 ? thr_lo : thr_hi);
    end
  end

  // Both clocks idle low until a frame runs
  initial begin
    first_ext_clock_in = 1'b0;
    second_ext_clock_in = 1'b0;
  end

  // ----------------------------------------------------------------
  // Stimulus tasks
  // ----------------------------------------------------------------
  task automatic init(input logic [15:0] p);
    pat = p;
  endtask

  // Second input held as a level, for qualifier use
  task automatic lvl2(input logic v);
    second_ext_clock_in = v;
  endtask

  // Clocks run only inside a frame; data moves on the first falling edge,
  // so it is settled long before the next rising edge
  task automatic frames(input int n, input logic [1:0] sel);
    #37;
    repeat (n) begin
      #200 if (sel[0]) first_ext_clock_in = 1'b1;
      #200 if (sel[1]) second_ext_clock_in = 1'b1;
      #200 if (sel[0]) first_ext_clock_in = 1'b0;
      pat = pat + 16'h0001;
      #200 if (sel[1]) second_ext_clock_in = 1'b0;
    end
    #63;
  endtask
endmodule
`default_nettype wire

/* File: efcf_front_tb_top.sv */
// Self-checking bench for the capture front end
`timescale 1ns/100ps
`default_nettype none

module efcf_front_tb_top;
  // ----------------------------------------------------------------
  // Signals and constants
  // ----------------------------------------------------------------
  localparam logic [3:0] F_IDLE = efcf_pkg::FSM_IDLE;
  localparam logic [3:0] F_ARM  = efcf_pkg::FSM_ARM;
  localparam logic [3:0] F_RUN  = efcf_pkg::FSM_RUN;
  localparam logic [3:0] F_DONE = efcf_pkg::FSM_DONE;
  // Mode, speed, count-qualifier triples packed two bits each
  localparam logic [5:0] BAD [5]  = '{6'h30, 6'h0C, 6'h03, 6'h16, 6'h19};
  localparam logic [5:0] GOOD [3] = '{6'h02, 6'h15, 6'h18};

  logic                ref_clk = 1'b0;
  logic                rstn = 1'b0;
  logic [15:0]         chan_above;
  logic                first_ext_clock_in;
  logic                second_ext_clock_in;
  logic                emu_valid = 1'b0;
  logic [31:0]         emu_bus = 32'h0;
  efcf_pkg::efcf_cfg_t cfg = '0;
  logic                trace_start = 1'b0;
  logic                trace_stop = 1'b0;
  logic                lbl_we = 1'b0;
  logic [1:0]          lbl_idx = 2'h0;
  logic [15:0]         lbl_mask = 16'h0;
  logic [1:0]          trig_lbl = 2'h0;
  logic [15:0]         trig_pat = 16'h0;
  logic [2:0]          rd_idx = 3'h0;
  logic                other_trig_in = 1'b0;
  logic                arm_other_out;
  logic [7:0]          thr_lo_out;
  logic [7:0]          thr_hi_out;
  efcf_pkg::efcf_fsm_t fsm_out;
  logic                cfg_err_out;
  logic                trig_out;
  logic [63:0]         lbl_masks_out;
  logic [15:0]         rd_data;
  logic                comb_valid;
  logic [47:0]         comb_data;
  int                  n_fail = 0;
  int                  n_tests = 0;
  int                  n_trig = 0;
  int                  n_arm = 0;

  // ----------------------------------------------------------------
  // Design, target model, clock and pulse counters
  // ----------------------------------------------------------------
  efcf_front efcf_front_i (
    .ref_clk, .rstn, .chan_above, .first_ext_clock_in, .second_ext_clock_in,
    .emu_valid, .emu_bus, .cfg_in(cfg), .trace_start, .trace_stop, .lbl_we,
    .lbl_idx, .lbl_mask, .trig_lbl, .trig_pat, .rd_idx, .other_trig_in,
    .arm_other_out, .thr_lo_out, .thr_hi_out, .fsm_out, .cfg_err_out,
    .trig_out, .lbl_masks_out, .rd_data, .comb_valid, .comb_data
  );

  efcf_target efcf_target_i (
    .thr_lo(thr_lo_out), .thr_hi(thr_hi_out), .chan_above,
    .first_ext_clock_in, .second_ext_clock_in
  );

  always #50 ref_clk = ~ref_clk;

  // Pulses are counted so one-cycle outputs are never missed
  always @(posedge ref_clk) begin
    if (trig_out === 1'b1) n_trig++;
    if (arm_other_out === 1'b1) n_arm++;
  end

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [63:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chkf(input logic [3:0] e);
    n_tests++;
    if (fsm_out !== e) begin
      n_fail++;
      $display("CHECK FAILED fsm_out expected %h seen %h", e, fsm_out);
    end
  endtask

  task automatic cfgset(input logic [5:0] m, input logic [2:0] f, s);
    cfg.mode = efcf_pkg::efcf_mode_t'(m[5:4]);
    cfg.speed = efcf_pkg::efcf_speed_t'(m[3:2]);
    cfg.cntq = efcf_pkg::efcf_cntq_t'(m[1:0]);
    cfg.ck_first = efcf_pkg::efcf_ckcfg_t'(f);
    cfg.ck_second = efcf_pkg::efcf_ckcfg_t'(s);
  endtask

  // Each pulse ends with an idle cycle so calls can follow directly
  task automatic go();
    trace_start = 1'b1;
    tick(1);
    trace_start = 1'b0;
    tick(1);
  endtask

  task automatic stop();
    trace_stop = 1'b1;
    tick(1);
    trace_stop = 1'b0;
    tick(1);
  endtask

  task automatic lbl(input logic [1:0] i, input logic [15:0] m);
    lbl_we = 1'b1;
    lbl_idx = i;
    lbl_mask = m;
    tick(1);
    lbl_we = 1'b0;
    tick(1);
  endtask

  // State capture on the target clocks; six cycles cover the pin sync
  task automatic ckcase(input logic [2:0] f, s, input logic [1:0] sel,
                        input logic l2, input int n1, n2, input logic dn);
    cfgset(6'h10, f, s);
    efcf_target_i.lvl2(l2);
    go();
    efcf_target_i.frames(n1, sel);
    tick(6);
    chkf(F_RUN);
    efcf_target_i.frames(n2, sel);
    tick(6);
    chkf(dn ? F_DONE : F_RUN);
    if (!dn) stop();
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int k;
    efcf_target_i.init(16'hA5C3);
    tick(8);
    rstn = 1'b1;
    tick(1);
    chkf(F_IDLE);
    chk("labels", lbl_masks_out, 64'h0000_0000_0000_FFFF);
    lbl(2'h1, 16'h00FF);
    lbl(2'h0, 16'h0000);
    chk("labels", lbl_masks_out, 64'h0000_0000_00FF_FFFF);
    // Conflicting settings are refused, legal ones run
    foreach (BAD[i]) begin
      cfgset(BAD[i], 3'h1, 3'h0);
      go();
      chk("cfg_err", 64'(cfg_err_out), 64'h1);
      chkf(F_IDLE);
    end
    foreach (GOOD[i]) begin
      cfgset(GOOD[i], 3'h1, 3'h0);
      go();
      chk("cfg_err", 64'(cfg_err_out), 64'h0);
      chkf(F_RUN);
      stop();
      chkf(F_DONE);
    end
    // Extension: upper byte reads low against the higher threshold
    cfgset(6'h00, 3'h0, 3'h0);
    cfg.thr_lo = 8'h1C;
    cfg.thr_hi = 8'h40;
    trig_lbl = 2'h1;
    trig_pat = 16'h55C3;
    n_trig = 0;
    n_arm = 0;
    go();
    chk("thr_lo", 64'(thr_lo_out), 64'h1C);
    chk("thr_hi", 64'(thr_hi_out), 64'h40);
    cfg.thr_lo = 8'h7F;
    tick(6);
    go();
    chk("thr_lo", 64'(thr_lo_out), 64'h1C);
    for (k = 0; k < 8; k++) begin
      emu_valid = 1'b1;
      emu_bus = 32'hC0DE_0000 + 32'(k);
      tick(1);
      emu_valid = 1'b0;
      chk("comb_valid", 64'(comb_valid), 64'h1);
      chk("comb_data", 64'(comb_data), 64'({16'h00C3, emu_bus}));
      tick(1);
    end
    chkf(F_DONE);
    chk("trig", 64'(n_trig), 64'h1);
    chk("arm_out", 64'(n_arm), 64'h0);
    // Timing mode stores every cycle and arms the other analyzer
    cfgset(6'h20, 3'h0, 3'h0);
    cfg.thr_lo = 8'h1C;
    trig_lbl = 2'h0;
    trig_pat = 16'h00C3;
    n_trig = 0;
    n_arm = 0;
    go();
    for (k = 0; k < 20 && fsm_out !== F_DONE; k++) tick(1);
    if (k == 20) begin
      n_fail++;
      give_verdict();
    end
    chk("trig", 64'(n_trig), 64'h1);
    chk("arm_out", 64'(n_arm), 64'h1);
    // Armed by the other analyzer
    cfgset(6'h10, 3'h1, 3'h0);
    cfg.arm_by_other = 1'b1;
    go();
    chkf(F_ARM);
    tick(3);
    chkf(F_ARM);
    other_trig_in = 1'b1;
    tick(1);
    other_trig_in = 1'b0;
    chkf(F_RUN);
    stop();
    go();
    stop();
    chkf(F_IDLE);
    cfg.arm_by_other = 1'b0;
    // Clock selections and qualifiers
    cfg.thr_hi = 8'h1C;
    efcf_target_i.init(16'h1230);
    ckcase(3'h1, 3'h0, 2'b01, 1'b0, 7, 1, 1'b1);
    for (k = 0; k < 8; k++) begin
      rd_idx = 3'(k);
      tick(1);
      chk("rd_data", 64'(rd_data), 64'(16'h1230 + 16'(k)));
    end
    ckcase(3'h2, 3'h0, 2'b01, 1'b0, 7, 1, 1'b1);
    ckcase(3'h3, 3'h0, 2'b01, 1'b0, 3, 1, 1'b1);
    ckcase(3'h1, 3'h4, 2'b01, 1'b1, 7, 1, 1'b1);
    ckcase(3'h1, 3'h5, 2'b01, 1'b1, 8, 0, 1'b0);
    ckcase(3'h0, 3'h1, 2'b11, 1'b0, 7, 1, 1'b1);
    ckcase(3'h1, 3'h1, 2'b11, 1'b0, 3, 1, 1'b1);
    ckcase(3'h1, 3'h2, 2'b11, 1'b0, 3, 1, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
